// *** shared/sdpci_pkg.sv ***
// Constants and types shared by both ends of the SDRAM pin command link.
// Assumes a single 125 MHz clock that feeds both ends and the narrow
// (16-bit, two byte lane) configuration.
package sdpci_pkg;

	// Pin widths of the narrow configuration
	localparam int DQ_W     = 16;
	localparam int BYTE_W   = 8;
	localparam int LANES    = 2;
	localparam int ADDR_W   = 12;
	localparam int BANK_W   = 2;
	localparam int BANKS    = 4;
	localparam int ROWS     = 4096;
	localparam int COLS     = 512;
	localparam int COL_W    = 9;
	localparam int CMD_W    = 4;
	localparam int MODE_W   = 12;
	localparam int BEAT_W   = 4;

	// Address fields
	localparam int AP_BIT   = 10;
	localparam int BL_LSB   = 0;
	localparam int BL_W     = 3;

	// Reduced flip-flop store: bank, row bit 0 and column bits 2:0
	localparam int STORE_ROW_W = 1;
	localparam int STORE_COL_W = 3;
	localparam int STORE_AW    = BANK_W + STORE_ROW_W + STORE_COL_W;
	localparam int STORE_DEPTH = 1 << STORE_AW;

	// Timing: clock period in ns, latencies in clock cycles
	localparam int CLK_PERIOD_NS = 8;
	localparam int MASK_LAT      = 2;
	localparam int READ_LAT      = 3;

	// Command code {chip select, row strobe, column strobe, write strobe}
	localparam logic [3:0] CMD_LMR = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_BST = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_INH = 4'h8;

	// Burst length codes in the mode word
	localparam logic [2:0] BL_CODE_1 = 3'h0;
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;

	typedef enum logic [2:0] {
		PWR_RUN,
		PWR_SUSPEND,
		PWR_ACT_PD,
		PWR_PRE_PD,
		PWR_SELF_REF,
		PWR_DEEP_PD
	} sdpci_pwr_e;

	// Beats per burst; continuous page is served as eight beats
	function automatic logic [3:0] sdpciBurstLen(input logic [2:0] code);
		case (code)
			BL_CODE_1: sdpciBurstLen = 4'h1;
			BL_CODE_2: sdpciBurstLen = 4'h2;
			BL_CODE_4: sdpciBurstLen = 4'h4;
			default:   sdpciBurstLen = 4'h8;
		endcase
	endfunction : sdpciBurstLen

endpackage : sdpci_pkg

// *** shared/sdpci_pins_if.sv ***
// Pin bundle between the memory controller and the SDRAM device.
// Assumes both ends run on the same sys_clk; resolves the shared data bus.
`timescale 1ns/1ns
interface sdpci_pins_if;
	logic                          cke;
	logic                          csN;
	logic                          rasN;
	logic                          casN;
	logic                          weN;
	logic [sdpci_pkg::BANK_W-1:0]  bankSelect;
	logic [sdpci_pkg::ADDR_W-1:0]  addr;
	logic                          lowLaneMask;
	logic                          highLaneMask;
	logic [sdpci_pkg::DQ_W-1:0]    hostDq;
	logic [sdpci_pkg::LANES-1:0]   hostDqOe;
	logic [sdpci_pkg::DQ_W-1:0]    devDq;
	logic [sdpci_pkg::LANES-1:0]   devDqOe;
	logic [sdpci_pkg::DQ_W-1:0]    dq;

	// Bus level per lane; an undriven lane reads as zero
	for (genvar l = 0; l < sdpci_pkg::LANES; l++) begin : gLane
		assign dq[l*sdpci_pkg::BYTE_W +: sdpci_pkg::BYTE_W] =
			devDqOe[l]  ? devDq[l*sdpci_pkg::BYTE_W +: sdpci_pkg::BYTE_W] :
			hostDqOe[l] ? hostDq[l*sdpci_pkg::BYTE_W +: sdpci_pkg::BYTE_W] :
			8'h00;
	end

	modport host (
		output cke, csN, rasN, casN, weN, bankSelect, addr,
		output lowLaneMask, highLaneMask, hostDq, hostDqOe,
		input  dq
	);

	modport dev (
		input  cke, csN, rasN, casN, weN, bankSelect, addr,
		input  lowLaneMask, highLaneMask, dq,
		output devDq, devDqOe
	);
endinterface : sdpci_pins_if

// *** src/sdpci_host.sv ***
// Controller end: turns user commands into registered pin levels.
// Assumes the device end answers reads with fixed READ_LAT cycles.
`timescale 1ns/1ns
module sdpci_host (
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	sdpci_pins_if.host                         pins,
	input  wire logic                          cmdValid,
	output logic                               cmdReady,
	input  wire logic [sdpci_pkg::CMD_W-1:0]   cmdOp,
	input  wire logic [sdpci_pkg::BANK_W-1:0]  cmdBank,
	input  wire logic [sdpci_pkg::ADDR_W-1:0]  cmdAddr,
	input  wire logic [sdpci_pkg::DQ_W-1:0]    cmdData,
	input  wire logic [sdpci_pkg::LANES-1:0]   cmdMask,
	input  wire logic                          cmdCke,
	output logic [sdpci_pkg::DQ_W-1:0]         rdData,
	output logic                               rdValid
);

	typedef struct packed {
		logic                          cke;
		logic [sdpci_pkg::CMD_W-1:0]   cmd;
		logic [sdpci_pkg::BANK_W-1:0]  bank;
		logic [sdpci_pkg::ADDR_W-1:0]  addr;
		logic [sdpci_pkg::LANES-1:0]   mask;
		logic [sdpci_pkg::DQ_W-1:0]    dq;
		logic [sdpci_pkg::LANES-1:0]   dqOe;
		logic [sdpci_pkg::BEAT_W-1:0]  bl;
		logic [sdpci_pkg::BEAT_W-1:0]  wrLeft;
		logic [sdpci_pkg::BEAT_W-1:0]  rdLeft;
		logic [sdpci_pkg::READ_LAT:0]  rdShift;
		logic                          rdValid;
		logic [sdpci_pkg::DQ_W-1:0]    rdData;
	} sdpci_host_s;

	sdpci_host_s hostState_reg;
	sdpci_host_s hostState_next;

	// Commands are taken only while the clock is enabled
	assign cmdReady = hostState_reg.cke;

	// Next pin levels and read tracking
	always_comb begin
		hostState_next         = hostState_reg;
		hostState_next.cke     = cmdCke;
		hostState_next.cmd     = sdpci_pkg::CMD_NOP;
		hostState_next.dqOe    = '0;
		hostState_next.rdShift = {hostState_reg.rdShift[sdpci_pkg::READ_LAT-1:0], 1'b0};
		hostState_next.rdValid = hostState_reg.rdShift[sdpci_pkg::READ_LAT];
		hostState_next.rdData  = pins.dq;
		if (hostState_reg.rdLeft != '0) begin
			hostState_next.rdShift[0] = 1'b1;
			hostState_next.rdLeft     = hostState_reg.rdLeft - 4'h1;
		end
		if (hostState_reg.wrLeft != '0) begin
			hostState_next.wrLeft = hostState_reg.wrLeft - 4'h1;
			hostState_next.dqOe   = '1;
			hostState_next.dq     = cmdData;
			hostState_next.mask   = (cmdValid && cmdReady) ? cmdMask : '1;
		end
		if (cmdValid && cmdReady) begin
			hostState_next.cmd  = cmdOp;
			hostState_next.bank = cmdBank;
			hostState_next.addr = cmdAddr;
			hostState_next.mask = cmdMask;
			if (cmdOp != sdpci_pkg::CMD_NOP) begin
				hostState_next.wrLeft = '0;
				hostState_next.dqOe   = '0;
			end
			case (cmdOp)
				sdpci_pkg::CMD_WR: begin
					hostState_next.dq     = cmdData;
					hostState_next.dqOe   = '1;
					hostState_next.wrLeft = hostState_reg.bl - 4'h1;
				end
				sdpci_pkg::CMD_RD: begin
					hostState_next.rdShift[0] = 1'b1;
					hostState_next.rdLeft     = hostState_reg.bl - 4'h1;
				end
				sdpci_pkg::CMD_LMR: begin
					hostState_next.bl = sdpci_pkg::sdpciBurstLen(
						cmdAddr[sdpci_pkg::BL_LSB +: sdpci_pkg::BL_W]);
				end
				sdpci_pkg::CMD_BST: begin
					hostState_next.rdLeft = '0;
				end
				default: begin
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hostState_reg     <= '0;
			hostState_reg.cmd <= sdpci_pkg::CMD_NOP;
			hostState_reg.bl  <= 4'h1;
		end else begin
			hostState_reg <= hostState_next;
		end
	end

	// Pins straight from flip-flops
	assign pins.cke          = hostState_reg.cke;
	assign pins.csN          = hostState_reg.cmd[3];
	assign pins.rasN         = hostState_reg.cmd[2];
	assign pins.casN         = hostState_reg.cmd[1];
	assign pins.weN          = hostState_reg.cmd[0];
	assign pins.bankSelect   = hostState_reg.bank;
	assign pins.addr         = hostState_reg.addr;
	assign pins.lowLaneMask  = hostState_reg.mask[0];
	assign pins.highLaneMask = hostState_reg.mask[1];
	assign pins.hostDq       = hostState_reg.dq;
	assign pins.hostDqOe     = hostState_reg.dqOe;
	assign rdData            = hostState_reg.rdData;
	assign rdValid           = hostState_reg.rdValid;

endmodule : sdpci_host

// *** src/sdpci_device.sv ***
// Device end: registered pin decoder, bank state, burst engine, lane masks
// and clock-enable power states, over a small flip-flop store.
// Assumes the controller meets all command spacing; no timing is checked.
`timescale 1ns/1ns

module sdpci_device (
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	sdpci_pins_if.dev                          pins,
	output logic [2:0]                         powerState,
	output logic [sdpci_pkg::BANKS-1:0]        bankOpen,
	output logic [sdpci_pkg::MODE_W-1:0]       modeCode
);

	localparam int BW = sdpci_pkg::BYTE_W;

	typedef struct packed {
		logic                                               cke;
		logic [sdpci_pkg::CMD_W-1:0]                        cmd;
		logic [sdpci_pkg::BANK_W-1:0]                       bank;
		logic [sdpci_pkg::ADDR_W-1:0]                       addr;
		logic [sdpci_pkg::LANES-1:0]                        mask;
		logic [sdpci_pkg::DQ_W-1:0]                         wrData;
		sdpci_pkg::sdpci_pwr_e                              pwr;
		logic [sdpci_pkg::BANKS-1:0]                        bankOpen;
		logic [sdpci_pkg::BANKS-1:0][sdpci_pkg::ADDR_W-1:0] openRow;
		logic [sdpci_pkg::MODE_W-1:0]                       mode;
		logic                                               burstRd;
		logic                                               burstWr;
		logic [sdpci_pkg::BEAT_W-1:0]                       beatsLeft;
		logic [sdpci_pkg::COL_W-1:0]                        col;
		logic [sdpci_pkg::BANK_W-1:0]                       burstBank;
		logic                                               autoPre;
		logic [sdpci_pkg::MASK_LAT-1:0]                     rdPipe;
		logic [sdpci_pkg::MASK_LAT-1:0][sdpci_pkg::LANES-1:0] maskPipe;
		logic [sdpci_pkg::DQ_W-1:0]                         dqStage;
		logic [sdpci_pkg::DQ_W-1:0]                         dqOut;
		logic [sdpci_pkg::STORE_DEPTH-1:0][sdpci_pkg::DQ_W-1:0] mem;
	} sdpci_dev_s;

	sdpci_dev_s devState_reg;
	sdpci_dev_s devState_next;

	// Store index: bank, low row bit, low column bits; other rows alias
	function automatic logic [sdpci_pkg::STORE_AW-1:0] storeIdx(
		input logic [sdpci_pkg::BANK_W-1:0] bank,
		input logic [sdpci_pkg::ADDR_W-1:0] row,
		input logic [sdpci_pkg::COL_W-1:0]  col
	);
		storeIdx = {bank, row[sdpci_pkg::STORE_ROW_W-1:0], col[sdpci_pkg::STORE_COL_W-1:0]};
	endfunction : storeIdx

	// Decoder, bank state, burst engine and power states
	always_comb begin
		logic                                doBeat;
		logic                                beatRd;
		logic [sdpci_pkg::BANK_W-1:0]        beatBank;
		logic [sdpci_pkg::COL_W-1:0]         beatCol;
		logic [sdpci_pkg::STORE_AW-1:0]      beatIdx;
		logic [sdpci_pkg::BEAT_W-1:0]        bl;
		logic                                cmdOn;
		logic                                lowPower;
		doBeat   = 1'b0;
		beatRd   = 1'b0;
		beatBank = devState_reg.burstBank;
		beatCol  = devState_reg.col;
		beatIdx  = '0;
		bl       = sdpci_pkg::sdpciBurstLen(devState_reg.mode[sdpci_pkg::BL_LSB +: sdpci_pkg::BL_W]);
		// Decoder off when chip select high
		cmdOn    = !devState_reg.cmd[3];
		lowPower = devState_reg.pwr inside {sdpci_pkg::PWR_ACT_PD, sdpci_pkg::PWR_PRE_PD,
			sdpci_pkg::PWR_SELF_REF, sdpci_pkg::PWR_DEEP_PD};
		devState_next = devState_reg;

		if (!lowPower) begin
			devState_next.cke    = pins.cke;
			devState_next.cmd    = {pins.csN, pins.rasN, pins.casN, pins.weN};
			devState_next.bank   = pins.bankSelect;
			devState_next.addr   = pins.addr;
			devState_next.mask   = {pins.highLaneMask, pins.lowLaneMask};
			devState_next.wrData = pins.dq;
		end

		devState_next.rdPipe   = {devState_reg.rdPipe[0], 1'b0};
		devState_next.maskPipe = {devState_reg.maskPipe[0], devState_reg.mask};
		devState_next.dqOut    = devState_reg.dqStage;

		case (devState_reg.pwr)
			sdpci_pkg::PWR_RUN: begin
				if (!devState_reg.cke) begin
					if (devState_reg.burstRd || devState_reg.burstWr) begin
						devState_next.pwr = sdpci_pkg::PWR_SUSPEND;
					end else if (cmdOn && devState_reg.cmd == sdpci_pkg::CMD_REF
						&& devState_reg.bankOpen == '0) begin
						devState_next.pwr = sdpci_pkg::PWR_SELF_REF;
					end else if (cmdOn && devState_reg.cmd == sdpci_pkg::CMD_BST
						&& devState_reg.bankOpen == '0) begin
						devState_next.pwr = sdpci_pkg::PWR_DEEP_PD;
					end else if (devState_reg.bankOpen != '0) begin
						devState_next.pwr = sdpci_pkg::PWR_ACT_PD;
					end else begin
						devState_next.pwr = sdpci_pkg::PWR_PRE_PD;
					end
				end else begin
					if (devState_reg.burstRd || devState_reg.burstWr) begin
						doBeat = 1'b1;
						beatRd = devState_reg.burstRd;
						devState_next.col       = devState_reg.col + 9'h001;
						devState_next.beatsLeft = devState_reg.beatsLeft - 4'h1;
						if (devState_reg.beatsLeft == 4'h1) begin
							devState_next.burstRd = 1'b0;
							devState_next.burstWr = 1'b0;
							if (devState_reg.autoPre) begin
								devState_next.bankOpen[devState_reg.burstBank] = 1'b0;
							end
						end
					end
					if (cmdOn) begin
						case (devState_reg.cmd)
							sdpci_pkg::CMD_ACT: begin
								devState_next.bankOpen[devState_reg.bank] = 1'b1;
								devState_next.openRow[devState_reg.bank]  = devState_reg.addr;
							end
							sdpci_pkg::CMD_RD, sdpci_pkg::CMD_WR: begin
								doBeat   = 1'b1;
								beatRd   = devState_reg.cmd == sdpci_pkg::CMD_RD;
								beatBank = devState_reg.bank;
								beatCol  = devState_reg.addr[sdpci_pkg::COL_W-1:0];
								devState_next.burstBank = devState_reg.bank;
								devState_next.autoPre   = devState_reg.addr[sdpci_pkg::AP_BIT];
								devState_next.col       = beatCol + 9'h001;
								devState_next.beatsLeft = bl - 4'h1;
								devState_next.burstRd   = beatRd && bl != 4'h1;
								devState_next.burstWr   = !beatRd && bl != 4'h1;
								devState_next.bankOpen[devState_reg.burstBank] =
									devState_reg.bankOpen[devState_reg.burstBank];
								if (bl == 4'h1 && devState_reg.addr[sdpci_pkg::AP_BIT]) begin
									devState_next.bankOpen[devState_reg.bank] = 1'b0;
								end
							end
							sdpci_pkg::CMD_PRE: begin
								if (devState_reg.addr[sdpci_pkg::AP_BIT]) begin
									devState_next.bankOpen = '0;
								end else begin
									devState_next.bankOpen[devState_reg.bank] = 1'b0;
								end
							end
							sdpci_pkg::CMD_LMR: begin
								devState_next.mode = devState_reg.addr;
							end
							sdpci_pkg::CMD_BST: begin
								devState_next.burstRd = 1'b0;
								devState_next.burstWr = 1'b0;
							end
							default: begin
							end
						endcase
					end
				end
			end
			sdpci_pkg::PWR_SUSPEND: begin
				if (devState_reg.cke) begin
					devState_next.pwr = sdpci_pkg::PWR_RUN;
				end
			end
			// Raw clock gate wakes the device
			sdpci_pkg::PWR_ACT_PD, sdpci_pkg::PWR_PRE_PD, sdpci_pkg::PWR_SELF_REF,
			sdpci_pkg::PWR_DEEP_PD: begin
				if (pins.cke) begin
					devState_next.pwr = sdpci_pkg::PWR_RUN;
					devState_next.cke = 1'b1;
					devState_next.cmd = sdpci_pkg::CMD_NOP;
				end
			end
			default: begin
				devState_next.pwr = sdpci_pkg::PWR_RUN;
			end
		endcase

		beatIdx = storeIdx(beatBank, devState_reg.openRow[beatBank], beatCol);
		if (doBeat && beatRd) begin
			devState_next.dqStage   = devState_reg.mem[beatIdx];
			devState_next.rdPipe[0] = 1'b1;
		end
		if (doBeat && !beatRd) begin
			for (int l = 0; l < sdpci_pkg::LANES; l++) begin
				if (!devState_reg.mask[l]) begin
					devState_next.mem[beatIdx][l*BW +: BW] = devState_reg.wrData[l*BW +: BW];
				end
			end
		end
	end

	// State register; there is no device reset pin, resetn stands in for power-up
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			devState_reg     <= '0;
			devState_reg.cke <= 1'b1;
			devState_reg.cmd <= sdpci_pkg::CMD_NOP;
		end else begin
			devState_reg <= devState_next;
		end
	end

	// Lane drivers off two clocks after mask
	for (genvar l = 0; l < sdpci_pkg::LANES; l++) begin : gOe
		assign pins.devDqOe[l] = devState_reg.rdPipe[sdpci_pkg::MASK_LAT-1]
			&& !devState_reg.maskPipe[sdpci_pkg::MASK_LAT-1][l];
	end

	// Status and data outputs from flip-flops
	assign pins.devDq = devState_reg.dqOut;
	assign powerState = devState_reg.pwr;
	assign bankOpen   = devState_reg.bankOpen;
	assign modeCode   = devState_reg.mode;

endmodule : sdpci_device

// *** tb/sdpci_assertions.sv ***
// Concurrent checks on the pin bundle between controller and device ends.
// Assumes one sys_clk for both ends; instanced beside the pin bundle.
`timescale 1ns/1ns
module sdpci_assertions (
	input wire logic                        sys_clk,
	input wire logic                        resetn,
	input wire logic                        cke,
	input wire logic                        csN,
	input wire logic                        rasN,
	input wire logic                        casN,
	input wire logic                        weN,
	input wire logic                        lowLaneMask,
	input wire logic                        highLaneMask,
	input wire logic [sdpci_pkg::LANES-1:0] hostDqOe,
	input wire logic [sdpci_pkg::LANES-1:0] devDqOe
);
	logic [3:0] pinCmd;
	logic       rdCmd;
	logic       wrCmd;
	logic       quiet;
	logic [3:0] sinceRd_reg;

	// Pin command decode; chip select high never counts as a command
	assign pinCmd = {csN, rasN, casN, weN};
	assign rdCmd  = cke && (pinCmd == sdpci_pkg::CMD_RD);
	assign wrCmd  = cke && (pinCmd == sdpci_pkg::CMD_WR);
	assign quiet  = cke && (csN || pinCmd == sdpci_pkg::CMD_NOP);

	// Cycles since last read; frozen while clock gated, as the burst is
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sinceRd_reg <= 4'hf;
		end else if (pinCmd == sdpci_pkg::CMD_RD) begin
			sinceRd_reg <= 4'h0;
		end else if (cke && sinceRd_reg != 4'hf) begin
			sinceRd_reg <= sinceRd_reg + 4'h1;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_low_lane_float: assert property (devDqOe[0] |-> !$past(lowLaneMask, 3))
		else $error("low lane driven although masked");
	a_high_lane_float: assert property (devDqOe[1] |-> !$past(highLaneMask, 3))
		else $error("high lane driven although masked");
	a_read_latency: assert property (rdCmd && $past(cke) && $past(cke, 2) && !lowLaneMask
		##1 quiet [*3] |-> devDqOe[0])
		else $error("read beat missing three cycles after read");
	a_burst_ends: assert property (devDqOe != 2'b00 |-> sinceRd_reg <= 4'hc)
		else $error("device drives bus without a selected read");
	a_no_contention: assert property ((hostDqOe & devDqOe) == 2'b00)
		else $error("both ends drive one lane");
	a_write_drives: assert property (wrCmd |-> hostDqOe != 2'b00)
		else $error("write command without write data drive");
	a_read_released: assert property (rdCmd ##1 quiet |-> hostDqOe == 2'b00)
		else $error("controller drives bus during read");
	a_suspend_float: assert property ((!cke) [*3] |=> devDqOe == 2'b00)
		else $error("device drives bus with clock gated");

	// Main traffic seen at least once
	c_read_beat: cover property (rdCmd ##3 devDqOe != 2'b00);
	c_write: cover property (wrCmd && hostDqOe == 2'b11);
	c_gated: cover property ((!cke) [*3]);
endmodule : sdpci_assertions

// *** tb/test_sdram_pin_command_interface.sv ***
// Self-checking bench: controller end and device end across the pin bundle.
// Assumes a 125 MHz sys_clk; inputs change on the falling edge only.
`timescale 1ns/1ns
module test_sdram_pin_command_interface;
	typedef struct {
		logic [1:0]  b;
		logic [11:0] a;
		logic [15:0] d;
		logic [1:0]  wm;
		logic [1:0]  rm;
		logic [15:0] e;
	} sdpci_row_s;

	logic        sys_clk  = 1'b0;
	logic        resetn   = 1'b0;
	logic        cmdValid = 1'b0;
	logic        cmdReady;
	logic [3:0]  cmdOp    = sdpci_pkg::CMD_NOP;
	logic [1:0]  cmdBank  = 2'h0;
	logic [11:0] cmdAddr  = 12'h000;
	logic [15:0] cmdData  = 16'h0000;
	logic [1:0]  cmdMask  = 2'h0;
	logic        cmdCke   = 1'b1;
	logic [15:0] rdData;
	logic        rdValid;
	logic [2:0]  powerState;
	logic [3:0]  bankOpen;
	logic [11:0] modeCode;
	int          fails    = 0;
	int          cmpCount = 0;
	// Write then read per row; masked lanes keep zero or read back as zero
	// Spare address bits stay low
	sdpci_row_s  tbl [6]  = '{
		'{2'h0, 12'h001, 16'ha5c3, 2'h0, 2'h0, 16'ha5c3},
		'{2'h1, 12'h002, 16'h1234, 2'h1, 2'h0, 16'h1200},
		'{2'h2, 12'h003, 16'h5678, 2'h2, 2'h0, 16'h0078},
		'{2'h3, 12'h004, 16'h9abc, 2'h0, 2'h1, 16'h9a00},
		'{2'h0, 12'h005, 16'hdef0, 2'h0, 2'h2, 16'h00f0},
		'{2'h1, 12'h006, 16'h0ff0, 2'h3, 2'h0, 16'h0000}};
	sdpci_pkg::sdpci_pwr_e pdExp [4] = '{sdpci_pkg::PWR_ACT_PD, sdpci_pkg::PWR_PRE_PD,
		sdpci_pkg::PWR_SELF_REF, sdpci_pkg::PWR_DEEP_PD};
	logic [3:0]  pdOp [4] = '{sdpci_pkg::CMD_NOP, sdpci_pkg::CMD_NOP, sdpci_pkg::CMD_REF,
		sdpci_pkg::CMD_BST};

	// Free-running 8 ns clock
	always #4 sys_clk = ~sys_clk;

	sdpci_pins_if sdpci_pins_if_i ();
	sdpci_host sdpci_host_i (.sys_clk(sys_clk), .resetn(resetn), .pins(sdpci_pins_if_i),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdBank(cmdBank),
		.cmdAddr(cmdAddr), .cmdData(cmdData), .cmdMask(cmdMask), .cmdCke(cmdCke),
		.rdData(rdData), .rdValid(rdValid));
	sdpci_device sdpci_device_i (.sys_clk(sys_clk), .resetn(resetn), .pins(sdpci_pins_if_i),
		.powerState(powerState), .bankOpen(bankOpen), .modeCode(modeCode));
	sdpci_assertions sdpci_assertions_i (.sys_clk(sys_clk), .resetn(resetn),
		.cke(sdpci_pins_if_i.cke), .csN(sdpci_pins_if_i.csN), .rasN(sdpci_pins_if_i.rasN),
		.casN(sdpci_pins_if_i.casN), .weN(sdpci_pins_if_i.weN),
		.lowLaneMask(sdpci_pins_if_i.lowLaneMask), .highLaneMask(sdpci_pins_if_i.highLaneMask),
		.hostDqOe(sdpci_pins_if_i.hostDqOe), .devDqOe(sdpci_pins_if_i.devDqOe));

	task automatic chkData(input logic [15:0] got, input logic [15:0] exp);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t data %h expected %h", $time, got, exp);
		end
	endtask : chkData

	task automatic chkState(input logic [3:0] got, input logic [3:0] exp);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t state %h expected %h", $time, got, exp);
		end
	endtask : chkState

	task automatic doReset();
		@(negedge sys_clk);
		resetn = 1'b0;
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (2) @(negedge sys_clk);
	endtask : doReset

	// One command, held until taken; valid drops at the next falling edge
	task automatic issue(input logic [3:0] op, input logic [1:0] bk, input logic [11:0] ad,
		input logic [15:0] dt, input logic [1:0] mk, input logic ck);
		@(negedge sys_clk);
		cmdValid = 1'b1;
		cmdOp    = op;
		cmdBank  = bk;
		cmdAddr  = ad;
		cmdData  = dt;
		cmdMask  = mk;
		cmdCke   = ck;
		while (cmdReady !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		cmdValid = 1'b0;
	endtask : issue

	// Bounded wait for a read beat; a miss yields unknown data
	task automatic readWait(output logic [15:0] got);
		int n;
		n = 0;
		while (rdValid !== 1'b1 && n < 16) begin
			@(negedge sys_clk);
			n++;
		end
		got = (n < 16) ? rdData : 16'hxxxx;
	endtask : readWait

	task automatic report_and_stop();
		if (fails == 0 && cmpCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	// Main sequence: table, then precharge, mode, power states, second reset
	initial begin
		logic [15:0] got;
		doReset();
		for (int i = 0; i < 4; i++) issue(sdpci_pkg::CMD_ACT, 2'(i), 12'h000, 16'h0, 2'h0, 1'b1);
		repeat (2) @(negedge sys_clk);
		chkState(bankOpen, 4'hf);
		for (int i = 0; i < 6; i++) begin
			issue(sdpci_pkg::CMD_WR, tbl[i].b, tbl[i].a, tbl[i].d, tbl[i].wm, 1'b1);
			issue(sdpci_pkg::CMD_RD, tbl[i].b, tbl[i].a, 16'h0, tbl[i].rm, 1'b1);
			readWait(got);
			chkData(got, tbl[i].e);
		end
		// Auto precharge read, single bank and all bank precharge
		issue(sdpci_pkg::CMD_RD, 2'h1, 12'h402, 16'h0, 2'h0, 1'b1);
		readWait(got);
		chkData(got, 16'h1200);
		repeat (4) @(negedge sys_clk);
		chkState(bankOpen, 4'hd);
		issue(sdpci_pkg::CMD_PRE, 2'h2, 12'h000, 16'h0, 2'h0, 1'b1);
		repeat (3) @(negedge sys_clk);
		chkState(bankOpen, 4'h9);
		issue(sdpci_pkg::CMD_PRE, 2'h2, 12'h400, 16'h0, 2'h0, 1'b1);
		repeat (3) @(negedge sys_clk);
		chkState(bankOpen, 4'h0);
		// Burst of two: second write beat masked, column counter steps
		issue(sdpci_pkg::CMD_LMR, 2'h0, 12'h001, 16'h0, 2'h0, 1'b1);
		repeat (3) @(negedge sys_clk);
		chkData({4'h0, modeCode}, 16'h0001);
		issue(sdpci_pkg::CMD_ACT, 2'h0, 12'h000, 16'h0, 2'h0, 1'b1);
		issue(sdpci_pkg::CMD_WR, 2'h0, 12'h000, 16'h1111, 2'h0, 1'b1);
		issue(sdpci_pkg::CMD_RD, 2'h0, 12'h000, 16'h0, 2'h0, 1'b1);
		readWait(got);
		chkData(got, 16'h1111);
		@(negedge sys_clk);
		readWait(got);
		chkData(got, 16'ha5c3);
		// Low-power entries by command and bank state, each left by the gate
		for (int i = 0; i < 4; i++) begin
			if (i == 1)
				issue(sdpci_pkg::CMD_PRE, 2'h0, 12'h400, 16'h0, 2'h0, 1'b1);
			issue(pdOp[i], 2'h0, 12'h000, 16'h0, 2'h0, 1'b0);
			repeat (4) @(negedge sys_clk);
			chkState({1'b0, powerState}, {1'b0, pdExp[i]});
			chkState({3'h0, cmdReady}, 4'h0);
			cmdCke = 1'b1;
			repeat (4) @(negedge sys_clk);
			chkState({1'b0, powerState}, {1'b0, sdpci_pkg::PWR_RUN});
		end
		// Gate dropped in mid burst freezes it
		issue(sdpci_pkg::CMD_ACT, 2'h0, 12'h000, 16'h0, 2'h0, 1'b1);
		issue(sdpci_pkg::CMD_RD, 2'h0, 12'h000, 16'h0, 2'h0, 1'b1);
		cmdCke = 1'b0;
		repeat (4) @(negedge sys_clk);
		chkState({1'b0, powerState}, {1'b0, sdpci_pkg::PWR_SUSPEND});
		cmdCke = 1'b1;
		repeat (6) @(negedge sys_clk);
		// Second reset, then a deselected activate must be ignored
		doReset();
		chkData({4'h0, modeCode}, 16'h0000);
		issue(4'hb, 2'h3, 12'h000, 16'h0, 2'h0, 1'b1);
		repeat (3) @(negedge sys_clk);
		chkState(bankOpen, 4'h0);
		report_and_stop();
	end

	// Watchdog: tests need about 200 cycles, limit well beyond that
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end
endmodule : test_sdram_pin_command_interface
